// File: rtl/gri_pkg.sv
// Package: constants and carriers for the remote initialization block
package gri_pkg;
  localparam int BYTE_W = 8;
  localparam int IBUF_DEPTH = 16;
  localparam int OQ_DEPTH = 16;
  localparam int SET_W = 32;
  localparam int MAV_BIT = 4;
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_PON_BIT = 7;
  localparam logic [7:0] ESR_RST = 8'h00;
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic [7:0] SRE_RST = 8'h00;
  // Clearing takes one cycle in the clear state
  localparam int CLR_CYCLES = 1;

  typedef enum logic [1:0] {
    GRI_ST_IDLE,
    GRI_ST_CLEAR,
    GRI_ST_RUN
  } gri_state_t;

  typedef struct packed {
    logic talk;
    logic listen;
    logic ctrl_act;
    logic sh_busy;
    logic ah_busy;
    logic srq_pend;
    logic remote;
    logic pp_cfg;
  } gri_if_t;

  typedef struct packed {
    logic opc_armed;
    logic opcq_armed;
  } gri_opc_t;
endpackage

// File: rtl/gri_init.sv
// Module: IEEE 488 remote interface initialization and message queues
// How it works
// RULE1: Interface clear idles handshake, talker, listener and controller.
// RULE2: Interface clear drops pending request; keeps remote, poll, trigger.
// RULE3: Interface clear leaves instrument settings untouched.
// RULE4: Device clear empties input buffer and output queue, clearing MAV.
// RULE5: Device clear resets parser, execution unit and response generator.
// RULE6: Device clear discards pending commands blocking a reset sequence.
// RULE7: Device clear forces operation-complete command handling idle.
// RULE8: Device clear forces operation-complete query handling idle.
// RULE9: After device clear, message parts sit idle awaiting the controller.
// RULE10: Device clear keeps settings, status bits other than MAV, operations.
// RULE11: Reset command loads the fixed predefined instrument state.
// RULE12: Reset command keeps interface state, address and output queue.
// RULE13: Reset command keeps enables, clear flag, calibration and setup.
// RULE14: Power-on restores saved settings, or defaults with preset held.
// RULE15: Power-on starts with empty input buffer and output queue.
// RULE16: Power-on resets parser, execution unit and response generator.
// RULE17: Power-on places both operation-complete handlers idle.
// RULE18: Power-on zeroes event status and its enable, then records events.
// RULE19: MAV sits at status bit 4, one while output queue holds data.
// RULE20: Each stimulus acts in bounded cycles; reception resumes afterwards.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module gri_init #(
  parameter int IBUF_D = gri_pkg::IBUF_DEPTH,
  parameter int OQ_D = gri_pkg::OQ_DEPTH,
  parameter logic [gri_pkg::SET_W-1:0] DEFAULT_SET = 32'h0000_0000
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Bus stimuli; clears and reset command are one-cycle pulses
  input wire logic ifc_i,
  input wire logic dcl_i,
  input wire logic sdc_i,
  input wire logic addressed_i,
  input wire logic rst_cmd_i,
  input wire logic preset_key_i,
  input wire logic [gri_pkg::SET_W-1:0] saved_set_i,
  // Interface function requests
  input wire logic if_set_i,
  input wire gri_pkg::gri_if_t if_req_i,
  // Input buffer write
  input wire logic in_valid_i,
  input wire logic [gri_pkg::BYTE_W-1:0] in_data_i,
  output logic in_ready_o,
  // Parser side read of input buffer
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output logic [gri_pkg::BYTE_W-1:0] cmd_data_o,
  // Response generator writes, talker reads
  input wire logic rsp_valid_i,
  input wire logic [gri_pkg::BYTE_W-1:0] rsp_data_i,
  input wire logic talk_read_i,
  output logic [gri_pkg::BYTE_W-1:0] talk_data_o,
  // Operation complete handling
  input wire logic opc_cmd_i,
  input wire logic opcq_cmd_i,
  input wire logic ops_done_i,
  input wire logic [7:0] event_i,
  input wire logic ese_wr_i,
  input wire logic sre_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output gri_pkg::gri_if_t if_state_o,
  output gri_pkg::gri_opc_t opc_state_o,
  output logic [gri_pkg::SET_W-1:0] settings_o,
  output logic [7:0] esr_o,
  output logic [7:0] ese_o,
  output logic [7:0] sre_o,
  output logic [7:0] stb_o,
  output logic parser_rst_o,
  output logic busy_o
);
  import gri_pkg::*;

  localparam int IA = $clog2(IBUF_D);
  localparam int OA = $clog2(OQ_D);

  function automatic logic [IA:0] inc_i(input logic [IA:0] p);
    inc_i = p + 1'b1;
  endfunction

  function automatic logic [OA:0] inc_o(input logic [OA:0] p);
    inc_o = p + 1'b1;
  endfunction

  logic [BYTE_W-1:0] ibuf [IBUF_D];
  logic [BYTE_W-1:0] oq [OQ_D];

  gri_state_t st_r, st_nxt;
  logic [IA:0] iw_r, iw_nxt, ir_r, ir_nxt;
  logic [OA:0] ow_r, ow_nxt, or_r, or_nxt;
  gri_if_t if_r, if_nxt;
  gri_opc_t opc_r, opc_nxt;
  logic [SET_W-1:0] set_r, set_nxt;
  logic [7:0] esr_r, esr_nxt, ese_r, ese_nxt, sre_r, sre_nxt;
  logic [BYTE_W-1:0] cmd_r, cmd_nxt, tdat_r, tdat_nxt;
  logic cmdv_r, cmdv_nxt;
  logic dev_clr, i_full, i_empty, o_full, o_empty, i_push, o_push;
  logic i_pop, o_pop;

  assign dev_clr = dcl_i | (sdc_i & addressed_i);
  assign i_full = (iw_r[IA] != ir_r[IA]) && (iw_r[IA-1:0] == ir_r[IA-1:0]);
  assign i_empty = (iw_r == ir_r);
  assign o_full = (ow_r[OA] != or_r[OA]) && (ow_r[OA-1:0] == or_r[OA-1:0]);
  assign o_empty = (ow_r == or_r);
  // Reception held off while a clear is pending or in progress
  assign in_ready_o = (st_r == GRI_ST_RUN) && !dev_clr && !i_full; // RULE20
  assign i_push = in_valid_i && in_ready_o;
  assign i_pop = (!cmdv_r || cmd_ready_i) && !i_empty && st_r == GRI_ST_RUN;
  assign o_pop = talk_read_i && !o_empty && st_r == GRI_ST_RUN;
  assign o_push = (rsp_valid_i || (opc_r.opcq_armed && ops_done_i))
                  && !o_full && st_r == GRI_ST_RUN && !dev_clr;

  always_comb begin
    st_nxt = st_r;
    iw_nxt = iw_r;
    ir_nxt = ir_r;
    ow_nxt = ow_r;
    or_nxt = or_r;
    if_nxt = if_r;
    opc_nxt = opc_r;
    set_nxt = set_r;
    esr_nxt = esr_r;
    ese_nxt = ese_r;
    sre_nxt = sre_r;
    cmd_nxt = cmd_r;
    cmdv_nxt = cmdv_r;
    tdat_nxt = tdat_r;
    case (st_r)
      GRI_ST_IDLE: begin
        // Power-on: pick saved or default settings
        set_nxt = preset_key_i ? DEFAULT_SET : saved_set_i; // RULE14
        st_nxt = GRI_ST_CLEAR;
      end
      GRI_ST_CLEAR: begin
        // Queues empty, parser idle; settings kept
        iw_nxt = '0; // RULE4 RULE15
        ir_nxt = '0; // RULE4 RULE15
        ow_nxt = '0; // RULE4 RULE15
        or_nxt = '0; // RULE4 RULE15
        cmdv_nxt = 1'b0; // RULE5 RULE6 RULE16
        opc_nxt = '0; // RULE7 RULE8 RULE17
        st_nxt = GRI_ST_RUN; // RULE9 RULE10
      end
      GRI_ST_RUN: begin
        if (i_push) begin
          iw_nxt = inc_i(iw_r);
        end
        if (i_pop) begin
          ir_nxt = inc_i(ir_r);
          cmd_nxt = ibuf[ir_r[IA-1:0]];
          cmdv_nxt = 1'b1;
        end else if (cmd_ready_i) begin
          cmdv_nxt = 1'b0;
        end
        if (o_push) begin
          ow_nxt = inc_o(ow_r);
        end
        if (o_pop) begin
          or_nxt = inc_o(or_r);
          tdat_nxt = oq[or_r[OA-1:0]];
        end
        if (opc_cmd_i) begin
          opc_nxt.opc_armed = 1'b1;
        end
        if (opcq_cmd_i) begin
          opc_nxt.opcq_armed = 1'b1;
        end
        if (ops_done_i) begin
          opc_nxt.opc_armed = 1'b0;
          opc_nxt.opcq_armed = 1'b0;
        end
        // Reset command touches only settings and exec state
        if (rst_cmd_i) begin
          set_nxt = DEFAULT_SET; // RULE11 RULE12 RULE13
          opc_nxt = '0;
        end
        if (ese_wr_i) begin
          ese_nxt = reg_wdata_i;
        end
        if (sre_wr_i) begin
          sre_nxt = reg_wdata_i;
        end
        if (dev_clr) begin
          st_nxt = GRI_ST_CLEAR; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE20
        end
      end
      default: st_nxt = GRI_ST_IDLE;
    endcase
    // Events keep recording in every state but idle; power-on bit set after zeroing
    if (st_r != GRI_ST_IDLE) begin
      esr_nxt = esr_r | event_i; // RULE18
      if (opc_r.opc_armed && ops_done_i && st_r == GRI_ST_RUN &&
          !dev_clr) begin
        esr_nxt[ESR_OPC_BIT] = 1'b1;
      end
    end else begin
      esr_nxt = ESR_RST;
      esr_nxt[ESR_PON_BIT] = 1'b1; // RULE18
    end
    // Interface functions follow requests; clear wins for every field, holding remote and pp_cfg
    if (if_set_i) begin
      if_nxt = if_req_i;
    end
    if (ifc_i) begin
      if_nxt.talk = 1'b0; // RULE1
      if_nxt.listen = 1'b0; // RULE1
      if_nxt.ctrl_act = 1'b0; // RULE1
      if_nxt.sh_busy = 1'b0; // RULE1
      if_nxt.ah_busy = 1'b0; // RULE1
      if_nxt.srq_pend = 1'b0; // RULE2
      if_nxt.remote = if_r.remote; // RULE2 RULE3
      if_nxt.pp_cfg = if_r.pp_cfg; // RULE2
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= GRI_ST_IDLE;
      iw_r <= '0;
      ir_r <= '0;
      ow_r <= '0;
      or_r <= '0;
      if_r <= '0;
      opc_r <= '0;
      set_r <= '0;
      esr_r <= ESR_RST;
      ese_r <= ESE_RST; // RULE18
      sre_r <= SRE_RST;
      cmd_r <= '0;
      cmdv_r <= 1'b0;
      tdat_r <= '0;
    end else begin
      st_r <= st_nxt;
      iw_r <= iw_nxt;
      ir_r <= ir_nxt;
      ow_r <= ow_nxt;
      or_r <= or_nxt;
      if_r <= if_nxt;
      opc_r <= opc_nxt;
      set_r <= set_nxt;
      esr_r <= esr_nxt;
      ese_r <= ese_nxt;
      sre_r <= sre_nxt;
      cmd_r <= cmd_nxt;
      cmdv_r <= cmdv_nxt;
      tdat_r <= tdat_nxt;
    end
  end

  // Memories carry no reset; pointers define their contents
  always_ff @(posedge core_clk_i) begin
    if (i_push) begin
      ibuf[iw_r[IA-1:0]] <= in_data_i;
    end
    if (o_push) begin
      oq[ow_r[OA-1:0]] <= rsp_valid_i ? rsp_data_i : 8'h31;
    end
  end

  always_comb begin
    stb_o = 8'h00;
    stb_o[MAV_BIT] = !o_empty; // RULE19
    stb_o[5] = |(esr_r & ese_r);
  end

  assign cmd_valid_o = cmdv_r;
  assign cmd_data_o = cmd_r;
  assign talk_data_o = tdat_r;
  assign if_state_o = if_r;
  assign opc_state_o = opc_r;
  assign settings_o = set_r;
  assign esr_o = esr_r;
  assign ese_o = ese_r;
  assign sre_o = sre_r;
  assign parser_rst_o = (st_r != GRI_ST_RUN);
  assign busy_o = (st_r != GRI_ST_RUN);
endmodule // gri_init

// File: tb/gri_init_assertions.sv
// Checker: timing of clears, power-on and status of the init block
`timescale 1ns/1ps
module gri_init_assertions (
  input logic core_clk_i,
  input logic sys_rst_i,
  input logic ifc_i,
  input logic dcl_i,
  input logic sdc_i,
  input logic rst_cmd_i,
  input logic if_set_i,
  input logic rsp_valid_i,
  input logic ese_wr_i,
  input logic sre_wr_i,
  input logic busy_o,
  input logic cmd_valid_o,
  input logic [7:0] stb_o,
  input logic [7:0] esr_o,
  input logic [7:0] ese_o,
  input logic [7:0] sre_o,
  input gri_pkg::gri_if_t if_state_o,
  input gri_pkg::gri_opc_t opc_state_o
);
  import gri_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_busy;
    dcl_i && !busy_o |=> busy_o ##1 !busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("clear busy");
  property p_clr_q;
    dcl_i && !busy_o |-> ##2 !stb_o[MAV_BIT] && !cmd_valid_o;
  endproperty
  a_clr_q: assert property (p_clr_q) else $error("queues");
  property p_clr_opc;
    dcl_i && !busy_o |-> ##2 opc_state_o == 2'b00;
  endproperty
  a_clr_opc: assert property (p_clr_opc) else $error("opc");
  property p_ifc_idle;
    ifc_i && !if_set_i |=> if_state_o[7:2] == 6'h00;
  endproperty
  a_ifc_idle: assert property (p_ifc_idle) else $error("ifc");
  property p_ifc_keep;
    ifc_i && !if_set_i |=> if_state_o[1:0] == $past(if_state_o[1:0]);
  endproperty
  a_ifc_keep: assert property (p_ifc_keep) else $error("ifc keep");
  property p_mav;
    rsp_valid_i && !busy_o && !dcl_i && !sdc_i |=> stb_o[MAV_BIT];
  endproperty
  a_mav: assert property (p_mav) else $error("mav");
  property p_rst_keep;
    rst_cmd_i && !ese_wr_i && !sre_wr_i |=> $stable(ese_o) && $stable(sre_o);
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("rst");
  property p_pon;
    $fell(sys_rst_i) |=> esr_o == 8'h80 && ese_o == 8'h00 && !stb_o[MAV_BIT];
  endproperty
  a_pon: assert property (p_pon) else $error("pon");
endmodule // gri_init_assertions

bind gri_init gri_init_assertions chk_u (.core_clk_i, .sys_rst_i, .ifc_i,
  .dcl_i, .sdc_i, .rst_cmd_i, .if_set_i, .rsp_valid_i, .ese_wr_i, .sre_wr_i,
  .busy_o, .cmd_valid_o, .stb_o, .esr_o, .ese_o, .sre_o, .if_state_o,
  .opc_state_o);

// File: tb/gri_host_model.sv
// Host controller model: bus clear commands and talker reads
`timescale 1ns/1ps
module gri_host_model (
  input wire logic core_clk_i,
  input wire logic busy_i,
  output logic ifc_o,
  output logic dcl_o,
  output logic sdc_o,
  output logic addressed_o,
  output logic talk_read_o
);
  initial {ifc_o, dcl_o, sdc_o, addressed_o, talk_read_o} = 5'h00;
  // Kind 0 interface clear, 1 device clear, 2 selected clear
  task automatic cmd(input int kind, input logic adr);
    int n;
    n = 0;
    @(posedge core_clk_i);
    addressed_o <= adr;
    {ifc_o, dcl_o, sdc_o} <= 3'b100 >> kind;
    @(posedge core_clk_i);
    {ifc_o, dcl_o, sdc_o} <= 3'b000;
    @(negedge core_clk_i);
    // Talking during the clear would be dropped, so wait it out
    while (busy_i && n < 20) begin
      n++;
      @(negedge core_clk_i);
    end
  endtask
  task automatic read();
    @(posedge core_clk_i);
    talk_read_o <= 1'b1;
    @(posedge core_clk_i);
    talk_read_o <= 1'b0;
  endtask
endmodule // gri_host_model

// File: tb/tb_top.sv
// Testbench: power-on, clears, reset command and talker traffic
`timescale 1ns/1ps
module tb_top;
  import gri_pkg::*;
  logic clk = 1'b0;
  logic rst, ifc, dcl, sdc, adr, pk, cv, tr, busy, ir, prs;
  logic [7:0] cd;
  logic [8:0] st;
  logic [7:0] wd, td, esr, ese, sre, stb;
  logic [SET_W-1:0] sv, set;
  logic [31:0] lf = 32'h4c9d;
  gri_if_t ifr, ifs;
  gri_opc_t ops;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int compares = 0;
  always #5 clk = ~clk;
  gri_host_model host_u (.core_clk_i(clk), .busy_i(busy), .ifc_o(ifc),
    .dcl_o(dcl), .sdc_o(sdc), .addressed_o(adr), .talk_read_o(tr));
  gri_init dut_u (.core_clk_i(clk), .sys_rst_i(rst), .ifc_i(ifc),
    .dcl_i(dcl), .sdc_i(sdc), .addressed_i(adr), .rst_cmd_i(st[0]),
    .preset_key_i(pk), .saved_set_i(sv), .if_set_i(st[1]), .if_req_i(ifr),
    .in_valid_i(st[8]), .in_data_i(wd), .in_ready_o(ir), .cmd_ready_i(1'b0),
    .cmd_valid_o(cv), .cmd_data_o(cd), .rsp_valid_i(st[2]), .rsp_data_i(wd),
    .talk_read_i(tr), .talk_data_o(td), .opc_cmd_i(st[3]),
    .opcq_cmd_i(st[4]), .ops_done_i(st[5]), .event_i(8'h00),
    .ese_wr_i(st[6]), .sre_wr_i(st[7]), .reg_wdata_i(wd), .if_state_o(ifs),
    .opc_state_o(ops), .settings_o(set), .esr_o(esr), .ese_o(ese),
    .sre_o(sre), .stb_o(stb), .parser_rst_o(prs), .busy_o(busy));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Strobe b: 0 reset cmd, 1 if load, 2 response, 3 opc, 4 opc query,
  // 5 ops done, 6 ese write, 7 sre write, 8 input byte
  task automatic p(input int b, input logic [7:0] d);
    @(posedge clk);
    st <= 9'h001 << b;
    wd <= d;
    @(posedge clk);
    st <= '0;
  endtask
  task automatic reset(input logic k);
    @(posedge clk);
    rst <= 1'b1;
    pk <= k;
    lf = nx(lf);
    sv <= lf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(set, k ? '0 : sv);
    chk({esr, ese, stb}, 24'h800000);
    chk(ops, 2'b00);
    chk({ir, prs, busy}, 3'b100);
  endtask
  // Talker bytes come out one cycle after each pop, in queue order
  always @(posedge clk) begin
    if (tr === 1'b1) begin
      @(negedge clk);
      chk(td, exp_q.pop_front());
    end
  end
  initial begin
    #100us;
    n_fail++;
    print_verdict();
  end
  initial begin
    st = '0;
    wd = '0;
    ifr = '1;
    reset(1'b1);
    reset(1'b0);
    p(1, 8'h00);
    host_u.cmd(0, 1'b0);
    chk(ifs, 8'h03);
    chk(set, sv);
    p(2, 8'h77);
    p(8, 8'h41);
    repeat (2) @(negedge clk);
    chk({cv, cd}, 9'h141);
    p(3, 8'h00);
    p(4, 8'h00);
    host_u.cmd(1, 1'b0);
    chk({stb[MAV_BIT], cv, ops}, 4'h0);
    p(5, 8'h00);
    @(negedge clk);
    chk({esr, stb}, 16'h8000);
    chk(set, sv);
    p(2, 8'h3c);
    host_u.cmd(2, 1'b0);
    chk(stb[MAV_BIT], 1'b1);
    host_u.cmd(2, 1'b1);
    chk(stb[MAV_BIT], 1'b0);
    p(4, 8'h00);
    p(5, 8'h00);
    exp_q.push_back(8'h31);
    lf = nx(lf);
    p(2, lf[7:0]);
    exp_q.push_back(lf[7:0]);
    p(6, 8'h21);
    p(7, 8'h30);
    p(0, 8'h00);
    @(negedge clk);
    chk({ese, sre, stb}, 24'h213010);
    chk(set, 32'h0000_0000);
    host_u.read();
    host_u.read();
    p(3, 8'h00);
    p(5, 8'h00);
    @(negedge clk);
    chk(stb, 8'h20);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // tb_top
